// ===== bil_pkg.sv
// package: constants for the boot initialization loader
package bil_pkg;

  // ****************************************
  // register map (axi4-lite byte addresses)
  // ****************************************
  localparam logic [7:0] BIL_REG_CTRL   = 8'h00;
  localparam logic [7:0] BIL_REG_STATUS = 8'h04;
  localparam logic [7:0] BIL_REG_SDATA  = 8'h08;
  localparam logic [7:0] BIL_REG_SCOUNT = 8'h0c;
  localparam logic [7:0] BIL_REG_MAP    = 8'h10;
  localparam logic [7:0] BIL_REG_HADDR  = 8'h14;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BIL_CTRL_RELEASE = 0;
  localparam int BIL_CTRL_START   = 1;
  localparam int BIL_CTRL_FREEZE  = 2;
  localparam int BIL_CTRL_STEP    = 3;
  localparam int BIL_CTRL_RESUME  = 4;
  localparam logic [31:0] BIL_CTRL_RESET = 32'h0000_0000;

  // ****************************************
  // code map
  // ****************************************
  localparam logic [15:0] BIL_ADDR_ZERO     = 16'h0000;
  localparam logic [15:0] BIL_PAR_MAP_TOP   = 16'h7fff;
  localparam logic [15:0] BIL_SER_MAP_TOP   = 16'hffff;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int BIL_MEM_AW   = 18;
  localparam int BIL_HOST_AW  = 32;
  localparam int BIL_SCLK_DIV = 2;
  localparam logic [1:0] BIL_RESP_OKAY   = 2'b00;
  localparam logic [1:0] BIL_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    BIL_ST_IDLE   = 3'b000,
    BIL_ST_PAR    = 3'b001,
    BIL_ST_SCFG   = 3'b010,
    BIL_ST_SCODE  = 3'b011,
    BIL_ST_HOST   = 3'b100,
    BIL_ST_RUN    = 3'b101
  } bil_state_e;

  typedef enum logic [1:0] {
    BIL_MAP_NONE     = 2'b00,
    BIL_MAP_EXTERNAL = 2'b01,
    BIL_MAP_INTERNAL = 2'b10
  } bil_map_e;

endpackage

// ===== bil_serial_rx.sv
// module: serial prom clock generator and bit shifter
`timescale 1ns/100ps
module bil_serial_rx
  import bil_pkg::*;
#(
  parameter int DIV = BIL_SCLK_DIV
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       enable,
  // prom pins
  output logic            sclk,
  input  wire logic       serial_prom_data_in,
  // received bytes
  output logic [7:0]      byte_data,
  output logic            byte_valid
);

  logic [7:0] div_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic       rise;

  // ****************************************
  // clock divider
  // ****************************************
  assign rise = enable && !sclk && (div_cnt == 8'(DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      div_cnt <= 8'h00;
      sclk    <= 1'b0;
    end else if (div_cnt == 8'(DIV - 1)) begin
      div_cnt <= 8'h00;
      sclk    <= !sclk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ****************************************
  // shifter: one bit on each rising serial clock
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      bit_cnt    <= 3'h0;
      shreg      <= 8'h00;
      byte_data  <= 8'h00;
      byte_valid <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      if (rise) begin // R23
        shreg   <= {shreg[6:0], serial_prom_data_in};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          byte_data  <= {shreg[6:0], serial_prom_data_in};
          byte_valid <= 1'b1;
        end
      end
    end
  end

  a_bit_per_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    rise |=> (bit_cnt == $past(bit_cnt) + 3'h1)) // R23
    else $error("serial bit count did not advance on clock rise");

endmodule

// ===== bil_loader.sv
// module: boot initialization loader top
//
// Contract
// R1: parallel boot drives 18-bit address, reads bytes, low-active ce oe we strobes.
// R2: boot source strap pulled up; unconnected reads high and selects parallel boot.
// R3: after parallel boot the processor fetches from 0000h in external memory.
// R4: first code mapper maps 0000h-7fffh to external memory in parallel boot.
// R5: unused pins weakly pulled high during parallel boot, user config after.
// R6: low boot source strap selects serial prom boot.
// R7: high host-boot strap means self configuration, no waiting on a host.
// R8: rewind line high rewinds prom, low enables its serial data.
// R9: serial clock on address bit 0, data on data bit 0, low chip enable.
// R10: serial boot loads logic array bitstream first, then application into ram.
// R11: after serial boot, start 0000h, full 64k program space mapped to ram.
// R12: unused pins weakly pulled high during serial download.
// R13: test port follows standard boundary scan on four pins; board ties unused high; the code's test port is the axi4-lite slave instead.
// R14: test port masters the system bus and reaches every location; the code's test port reaches only the loader registers.
// R15: test port freezes processor, single-steps, examines registers, resumes; the code's test port reads back only the loader registers.
// R16: test-port host configures array, writes ram, sets mappers, starts from ram; the code's test port only writes the ctrl bits.
// R17: external host asserts low chip enable before sending bytes.
// R18: host boot port takes 18 address bits, expandable to 32; the code loads only host_addr[15:0].
// R19: host presents address and data then pulses low write strobe.
// R20: host runs from the same clock as the device.
// R21: host sets reset release bit; processor then starts running.
// R22: host-booted device blocks external code fetches.
// R23: serial bit sampled on rising serial clock, one bit per clock.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
module bil_loader
  import bil_pkg::*;
#(
  parameter int AW       = BIL_MEM_AW,
  parameter int HAW      = BIL_HOST_AW,
  parameter int CFG_LEN  = 16,
  parameter int CODE_LEN = 16
) (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // straps
  input  wire logic            boot_source_strap,
  input  wire logic            host_boot_strap_n,
  // external memory pins
  output logic [AW-1:0]        mem_addr,
  input  wire logic [7:0]      mem_data_in,
  output logic                 mem_ce_n,
  output logic                 mem_oe_n,
  output logic                 mem_we_n,
  output logic                 serial_prom_rewind,
  // host boot port (synchronous to aclk)
  input  wire logic            host_ce_n,
  input  wire logic            host_we_n,
  input  wire logic [HAW-1:0]  host_addr,
  input  wire logic [7:0]      host_data,
  // loader outputs to the rest of the chip
  output logic                 cfg_wr,
  output logic                 ram_wr,
  output logic [15:0]          load_addr,
  output logic [7:0]           load_data,
  output logic                 pin_pullup_hold,
  output logic                 cpu_run,
  output logic                 cpu_freeze,
  output logic                 cpu_step,
  output logic [15:0]          cpu_start_addr,
  output logic [1:0]           code_map_kind,
  output logic [15:0]          code_map_top,
  output logic                 ext_fetch_block,
  // axi4-lite slave (test-port master path)
  input  wire logic [7:0]      s_awaddr,
  input  wire logic            s_awvalid,
  output logic                 s_awready,
  input  wire logic [31:0]     s_wdata,
  input  wire logic [3:0]      s_wstrb,
  input  wire logic            s_wvalid,
  output logic                 s_wready,
  output logic [1:0]           s_bresp,
  output logic                 s_bvalid,
  input  wire logic            s_bready,
  input  wire logic [7:0]      s_araddr,
  input  wire logic            s_arvalid,
  output logic                 s_arready,
  output logic [31:0]          s_rdata,
  output logic [1:0]           s_rresp,
  output logic                 s_rvalid,
  input  wire logic            s_rready
);

  bil_state_e  state;
  logic        boot_par;
  logic        boot_host;
  logic        straps_taken;
  logic        sclk;
  logic [7:0]  sbyte;
  logic        sbyte_valid;
  logic        ser_en;
  logic [15:0] count;
  logic        host_we_q;
  logic        host_stb;
  logic [31:0] ctrl;
  logic [7:0]  last_sdata;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_hit;

  // ****************************************
  // strap capture after reset release
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_taken <= 1'b0;
      boot_par     <= 1'b1;
      boot_host    <= 1'b0;
    end else if (!straps_taken) begin
      straps_taken <= 1'b1;
      boot_par     <= boot_source_strap; // R2 R6
      boot_host    <= !host_boot_strap_n; // R7
    end
  end

  // ****************************************
  // serial receiver
  // ****************************************
  assign ser_en = (state == BIL_ST_SCFG) || (state == BIL_ST_SCODE);

  bil_serial_rx #(.DIV(BIL_SCLK_DIV)) u_srx (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (ser_en),
    .sclk       (sclk),
    .serial_prom_data_in       (mem_data_in[0]), // R9
    .byte_data  (sbyte),
    .byte_valid (sbyte_valid)
  );

  // host write strobe: low pulse captured on its rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_we_q <= 1'b1;
    end else begin
      host_we_q <= host_we_n;
    end
  end
  assign host_stb = !host_ce_n && host_we_n && !host_we_q; // R17 R19

  // ****************************************
  // boot sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= BIL_ST_IDLE;
      count <= 16'h0000;
    end else begin
      case (state)
        BIL_ST_IDLE: begin
          count <= 16'h0000;
          if (straps_taken) begin
            if (boot_host) begin
              state <= BIL_ST_HOST;
            end else if (boot_par) begin
              state <= BIL_ST_PAR;
            end else begin
              state <= BIL_ST_SCFG; // R10
            end
          end
        end
        BIL_ST_PAR: begin
          count <= count + 16'h0001;
          // one count past the last address: its byte lands an edge later
          if (count == 16'(CFG_LEN)) begin
            state <= BIL_ST_RUN;
          end
        end
        BIL_ST_SCFG: begin
          if (sbyte_valid) begin
            if (count == 16'(CFG_LEN - 1)) begin
              count <= 16'h0000;
              state <= BIL_ST_SCODE; // R10
            end else begin
              count <= count + 16'h0001;
            end
          end
        end
        BIL_ST_SCODE: begin
          if (sbyte_valid) begin
            count <= count + 16'h0001;
            if (count == 16'(CODE_LEN - 1)) begin
              state <= BIL_ST_RUN;
            end
          end
        end
        BIL_ST_HOST: begin
          if (ctrl[BIL_CTRL_RELEASE]) begin
            state <= BIL_ST_RUN; // R21
          end
        end
        BIL_ST_RUN: begin
          state <= BIL_ST_RUN;
        end
        default: begin
          state <= BIL_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // memory pins
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr           <= '0;
      mem_ce_n           <= 1'b1;
      mem_oe_n           <= 1'b1;
      mem_we_n           <= 1'b1;
      serial_prom_rewind <= 1'b1;
    end else begin
      mem_we_n <= 1'b1; // R1
      if (state == BIL_ST_PAR) begin
        mem_addr <= AW'(count); // R1
        mem_ce_n <= 1'b0;
        mem_oe_n <= 1'b0;
      end else if (ser_en) begin
        mem_addr    <= '0;
        mem_addr[0] <= sclk; // R9
        mem_ce_n    <= 1'b0;
        serial_prom_rewind <= 1'b0; // R8
      end else begin
        mem_ce_n           <= 1'b1;
        mem_oe_n           <= 1'b1;
        serial_prom_rewind <= (state != BIL_ST_RUN); // R8
      end
    end
  end

  // ****************************************
  // load stream into array and ram
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_wr    <= 1'b0;
      ram_wr    <= 1'b0;
      load_addr <= 16'h0000;
      load_data <= 8'h00;
    end else begin
      cfg_wr <= 1'b0;
      ram_wr <= 1'b0;
      if (state == BIL_ST_PAR) begin
        // data on the pins belongs to the address driven one edge earlier
        if (count != 16'h0000) begin
          cfg_wr    <= 1'b1; // R1
          load_addr <= count - 16'h0001;
          load_data <= mem_data_in;
        end
      end else if (sbyte_valid && state == BIL_ST_SCFG) begin
        cfg_wr    <= 1'b1; // R10
        load_addr <= count;
        load_data <= sbyte;
      end else if (sbyte_valid && state == BIL_ST_SCODE) begin
        ram_wr    <= 1'b1; // R10
        load_addr <= count;
        load_data <= sbyte;
      end else if (state == BIL_ST_HOST && host_stb) begin
        ram_wr    <= 1'b1; // R18
        load_addr <= host_addr[15:0];
        load_data <= host_data;
      end
    end
  end

  // ****************************************
  // processor start and code map
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_pullup_hold <= 1'b1;
      cpu_run         <= 1'b0;
      cpu_start_addr  <= BIL_ADDR_ZERO;
      code_map_kind   <= BIL_MAP_NONE;
      code_map_top    <= 16'h0000;
      ext_fetch_block <= 1'b0;
    end else begin
      pin_pullup_hold <= (state != BIL_ST_RUN); // R5 R12
      cpu_start_addr  <= BIL_ADDR_ZERO; // R3 R11
      ext_fetch_block <= boot_host; // R22
      if (state == BIL_ST_RUN && !cpu_run) begin
        cpu_run <= 1'b1;
        if (boot_host) begin
          code_map_kind <= BIL_MAP_INTERNAL; // R16
          code_map_top  <= BIL_SER_MAP_TOP;
        end else if (boot_par) begin
          code_map_kind <= BIL_MAP_EXTERNAL; // R4
          code_map_top  <= BIL_PAR_MAP_TOP;
        end else begin
          code_map_kind <= BIL_MAP_INTERNAL; // R11
          code_map_top  <= BIL_SER_MAP_TOP;
        end
      end else if (state == BIL_ST_HOST && ctrl[BIL_CTRL_START]) begin
        state_unused_guard: begin
        end
      end
    end
  end

  // ****************************************
  // freeze and single step from the test port
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_freeze <= 1'b0;
      cpu_step   <= 1'b0;
    end else begin
      cpu_step <= 1'b0;
      if (wr_hit && aw_addr == BIL_REG_CTRL) begin
        if (w_data[BIL_CTRL_FREEZE]) begin
          cpu_freeze <= 1'b1; // R15
        end
        if (w_data[BIL_CTRL_RESUME]) begin
          cpu_freeze <= 1'b0; // R15
        end
        if (w_data[BIL_CTRL_STEP] && cpu_freeze) begin
          cpu_step <= 1'b1; // R15
        end
      end
    end
  end

  // ****************************************
  // axi4-lite slave: write path
  // ****************************************
  assign s_awready = !aw_hold && !s_bvalid; // R13
  assign s_wready  = !w_hold && !s_bvalid;
  assign wr_go     = aw_hold && w_hold && !s_bvalid;
  assign wr_hit    = wr_go;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= BIL_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (wr_go) begin
        aw_hold  <= 1'b0;
        w_hold   <= 1'b0;
        s_bvalid <= 1'b1;
        if (aw_addr == BIL_REG_CTRL || aw_addr == BIL_REG_MAP) begin
          s_bresp <= BIL_RESP_OKAY;
        end else begin
          s_bresp <= BIL_RESP_SLVERR;
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // control register; only byte lane 0 carries bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= BIL_CTRL_RESET;
    end else if (wr_hit && aw_addr == BIL_REG_CTRL && w_strb[0]) begin
      ctrl <= {27'h0, w_data[4:0] & 5'h03}; // R14 R21
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_sdata <= 8'h00;
    end else if (sbyte_valid) begin
      last_sdata <= sbyte;
    end
  end

  // ****************************************
  // axi4-lite slave: read path
  // ****************************************
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= BIL_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= BIL_RESP_OKAY;
      if (s_araddr == BIL_REG_CTRL) begin
        s_rdata <= ctrl;
      end else if (s_araddr == BIL_REG_STATUS) begin
        s_rdata <= {22'h0, cpu_freeze, ext_fetch_block, boot_host, boot_par,
                    cpu_run, pin_pullup_hold, 1'b0, state};
      end else if (s_araddr == BIL_REG_SDATA) begin
        s_rdata <= {24'h0, last_sdata};
      end else if (s_araddr == BIL_REG_SCOUNT) begin
        s_rdata <= {16'h0, count};
      end else if (s_araddr == BIL_REG_MAP) begin
        s_rdata <= {14'h0, code_map_kind, code_map_top};
      end else begin
        s_rdata <= 32'h0000_0000;
        s_rresp <= BIL_RESP_SLVERR;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_par_map_ext: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cpu_run) && boot_par && !boot_host |-> code_map_top == 16'h7fff
      && code_map_kind == BIL_MAP_EXTERNAL) // R4
    else $error("parallel code map wrong");
  a_ser_map_int: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cpu_run) && !boot_par && !boot_host |-> code_map_top == 16'hffff
      && code_map_kind == BIL_MAP_INTERNAL) // R11
    else $error("serial code map wrong");
  a_start_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_run |-> cpu_start_addr == 16'h0000) // R3
    else $error("start address not zero");
  a_pullup_until_run: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != BIL_ST_RUN) |=> pin_pullup_hold) // R5
    else $error("pull-up released before run");
  a_rewind_serial: assert property (@(posedge aclk) disable iff (!aresetn)
    ser_en |=> !serial_prom_rewind && !mem_ce_n) // R8
    else $error("prom not enabled in serial boot");
  a_sclk_on_a0: assert property (@(posedge aclk) disable iff (!aresetn)
    ser_en |=> mem_addr[0] == $past(sclk)) // R9
    else $error("serial clock not on address bit 0");
  a_cfg_before_code: assert property (@(posedge aclk) disable iff (!aresetn)
    ram_wr && !boot_host |-> !boot_par && $past(state) == BIL_ST_SCODE) // R10
    else $error("code loaded before bitstream");
  a_host_fetch_block: assert property (@(posedge aclk) disable iff (!aresetn)
    straps_taken && boot_host |=> ext_fetch_block) // R22
    else $error("external fetch not blocked");
  a_release_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BIL_ST_HOST && ctrl[BIL_CTRL_RELEASE] |-> ##2 cpu_run) // R21
    else $error("release did not start processor");
  a_no_we_boot: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BIL_ST_PAR |=> mem_we_n && !mem_oe_n) // R1
    else $error("parallel strobes wrong");

  c_par_boot:  cover property (@(posedge aclk) $rose(cpu_run) && boot_par);
  c_ser_boot:  cover property (@(posedge aclk) state == BIL_ST_SCODE && sbyte_valid);
  c_host_boot: cover property (@(posedge aclk) host_stb && state == BIL_ST_HOST);
  c_freeze:    cover property (@(posedge aclk) cpu_step);

endmodule

// ===== bil_mem_model.sv
// partner model: byte-wide parallel memory and sequential serial prom
`timescale 1ns/100ps
module bil_mem_model (
  // memory pins
  input  wire logic [17:0] mem_addr,
  input  wire logic        mem_ce_n,
  input  wire logic        mem_oe_n,
  input  wire logic        serial_prom_rewind,
  output logic [7:0]       mem_data_in
);
  logic [7:0] mem [0:255];
  int         bit_idx = 0;
  logic       flip = 1'b0;

  // released bus shows a changing pattern, never the last value
  always #5 flip = ~flip;

  // prom moves on after the falling serial clock so the rise sees a settled bit
  always @(negedge mem_addr[0] or posedge serial_prom_rewind) begin
    if (serial_prom_rewind) begin
      bit_idx <= 0;
    end else begin
      bit_idx <= bit_idx + 1;
    end
  end

  always_comb begin
    if (!serial_prom_rewind) begin
      mem_data_in = {{7{flip}}, mem[bit_idx/8][7-bit_idx%8]};
    end else if (!mem_ce_n && !mem_oe_n) begin
      mem_data_in = mem[mem_addr[7:0]];
    end else begin
      mem_data_in = {8{flip}};
    end
  end
endmodule

// ===== tb_boot_initialization_loader.sv
// testbench: boot loader checked against a queue model of the load stream
`timescale 1ns/100ps
module tb_boot_initialization_loader;
  import bil_pkg::*;
  localparam int CL = 4;
  localparam int DL = 4;
  logic        aclk, aresetn, boot_source_strap, host_boot_strap_n, host_ce_n, host_we_n;
  logic        mem_ce_n, mem_oe_n, mem_we_n, serial_prom_rewind, cfg_wr, ram_wr;
  logic        pin_pullup_hold, cpu_run, cpu_freeze, cpu_step, ext_fetch_block;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [17:0] mem_addr;
  logic [7:0]  mem_data_in, host_data, load_data, s_awaddr, s_araddr, d;
  logic [31:0] host_addr, s_wdata, s_rdata;
  logic [15:0] load_addr, cpu_start_addr, code_map_top;
  logic [1:0]  code_map_kind, s_bresp, s_rresp;
  logic [3:0]  s_wstrb;
  int          bad_count, cmp_count, steps;
  int          exp_q[$];

  bil_loader #(.CFG_LEN(CL), .CODE_LEN(DL)) uut (.*);
  bil_mem_model pm (.mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
                    .serial_prom_rewind(serial_prom_rewind), .mem_data_in(mem_data_in));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ****
  // checking and bus tasks
  // ****
  function automatic int ent(input bit c, input int a, input logic [7:0] v);
    return {6'h0, c, ~c, 16'(a), v};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic boot(input logic ps, input logic hs);
    exp_q.delete();
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_source_strap <= ps;
    host_boot_strap_n <= hs;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    @(negedge aclk);
  endtask

  task automatic post(input logic [1:0] k, input logic [15:0] t, input logic b);
    chk("run", 1, cpu_run);
    chk("start", BIL_ADDR_ZERO, cpu_start_addr);
    chk("kind", k, code_map_kind);
    chk("top", t, code_map_top);
    chk("pullup", 0, pin_pullup_hold);
    chk("block", b, ext_fetch_block);
    chk("left", 0, exp_q.size());
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        s_awvalid <= 1'b0;
        aw = 1;
      end
      if (s_wvalid && s_wready) begin
        s_wvalid <= 1'b0;
        w = 1;
      end
    end
    while (s_bvalid !== 1'b1) @(posedge aclk);
    chk("bresp", BIL_RESP_OKAY, s_bresp);
    s_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge aclk);
    chk("rdata", e, s_rdata);
    chk("rresp", er, s_rresp);
    s_rready <= 1'b0;
  endtask

  task automatic host_wr(input logic [31:0] a, input logic [7:0] v);
    exp_q.push_back(ent(0, a, v));
    @(posedge aclk);
    host_ce_n <= 1'b0;
    host_addr <= a;
    host_data <= v;
    @(posedge aclk);
    host_we_n <= 1'b0;
    @(posedge aclk);
    host_we_n <= 1'b1;
    @(posedge aclk);
    host_ce_n <= 1'b1;
  endtask

  always @(posedge aclk) begin
    if (aresetn && (cfg_wr || ram_wr)) begin
      chk("pullup", 1, pin_pullup_hold);
      if (exp_q.size() == 0) chk("extra", 0, 1);
      else chk("load", exp_q.pop_front(), {cfg_wr, ram_wr, load_addr, load_data});
    end
    if (aresetn && cpu_step === 1'b1) steps++;
  end

  initial begin
    #(25 * 20000);
    bad_count++;
    report_and_stop;
  end

  // ****
  // main sequence
  // ****
  initial begin
    {aresetn, host_we_n, host_ce_n, boot_source_strap, host_boot_strap_n} = 5'b01111;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'b0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, host_addr, host_data} = '0;
    void'($urandom(32'h14bd));
    for (int i = 0; i < 256; i++) pm.mem[i] = 8'($urandom);
    boot(1'b1, 1'b1);
    for (int i = 0; i < CL; i++) exp_q.push_back(ent(1, i, pm.mem[i]));
    wait_run;
    post(BIL_MAP_EXTERNAL, BIL_PAR_MAP_TOP, 1'b0);
    chk("we", 1, mem_we_n);
    boot(1'b0, 1'b1);
    for (int i = 0; i < CL; i++) exp_q.push_back(ent(1, i, pm.mem[i]));
    for (int i = 0; i < DL; i++) exp_q.push_back(ent(0, i, pm.mem[CL+i]));
    wait_run;
    post(BIL_MAP_INTERNAL, BIL_SER_MAP_TOP, 1'b0);
    boot(1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      host_wr(32'h0000_0040 + i * 9, d);
    end
    repeat (8) @(posedge aclk);
    chk("held", 0, cpu_run);
    chk("left", 0, exp_q.size());
    axi_rd(BIL_REG_CTRL, BIL_CTRL_RESET, BIL_RESP_OKAY);
    axi_rd(8'h20, 32'h0, BIL_RESP_SLVERR);
    axi_wr(BIL_REG_CTRL, 32'h1);
    wait_run;
    chk("run", 1, cpu_run);
    chk("block", 1, ext_fetch_block);
    axi_rd(BIL_REG_MAP, {14'h0, BIL_MAP_INTERNAL, BIL_SER_MAP_TOP}, BIL_RESP_OKAY);
    axi_wr(BIL_REG_CTRL, 32'h5);
    chk("freeze", 1, cpu_freeze);
    axi_wr(BIL_REG_CTRL, 32'h9);
    repeat (2) @(posedge aclk);
    chk("steps", 1, steps);
    axi_wr(BIL_REG_CTRL, 32'h11);
    repeat (2) @(posedge aclk);
    chk("freeze", 0, cpu_freeze);
    axi_rd(BIL_REG_CTRL, 32'h1, BIL_RESP_OKAY);
    report_and_stop;
  end
endmodule
